// file: dv/tb.sv
// Self-checking testbench of the halt and subtract executor
`timescale 1ns/1ps
`default_nettype none

module tb
	import sse_pkg::*;
;
	logic			aclk, aresetn, clk_en, wake_event;
	instr_t			instr;
	logic [7:0]		file_rdata, w_reg, w_old;
	file_wr_t		file_wr;
	logic			carry, digit_carry_flag, zero, timeout_flag;
	logic			powerdown_flag, halted, osc_run, watchdog_clear;
	logic [3:0]		awaddr, araddr, wstrb;
	logic [31:0]	wdata, rdata, rd_val;
	logic			awvalid, awready, wvalid, wready, bvalid, bready;
	logic			arvalid, arready, rvalid, rready;
	logic [1:0]		bresp, rresp, rd_resp, wr_resp;
	int				miscompares, tests_run, cycles;

	sleep_and_subtract_exec uut (.aclk(aclk), .aresetn(aresetn),
		.clk_en(clk_en), .instr(instr), .file_rdata(file_rdata),
		.wake_event(wake_event), .file_wr(file_wr), .w_reg(w_reg),
		.carry(carry), .digit_carry_flag(digit_carry_flag), .zero(zero),
		.timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
		.halted(halted), .osc_run(osc_run),
		.watchdog_clear(watchdog_clear), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready));

	// ----------------------------------------------------------------
	// Clock, timeout and reporting
	// ----------------------------------------------------------------
	always #4 aclk = ~aclk;

	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			finish_test();
		end
	end

	task automatic finish_test();
		$display("compares=%0d mismatches=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Expected {result, carry, digit carry, zero} of a minus b
	function automatic logic [10:0] sub_exp(input logic [7:0] a, b);
		logic [7:0] r;
		r = a - b;
		return {r, a >= b, a[3:0] >= b[3:0], r == 8'h00};
	endfunction

	// ----------------------------------------------------------------
	// Bus and instruction drivers
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		logic b_done;
		b_done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_done)
		begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid && bready)
			begin
				bready <= 1'b0;
				wr_resp = bresp;
				b_done = 1'b1;
			end
		end
	endtask

	task automatic axi_rd(input logic [3:0] a);
		logic r_done;
		r_done = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_done)
		begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid && rready)
			begin
				rready <= 1'b0;
				rd_val = rdata;
				rd_resp = rresp;
				r_done = 1'b1;
			end
		end
	endtask

	task automatic ex(input logic [13:0] w, input logic [7:0] f);
		@(posedge aclk);
		instr <= '{valid: 1'b1, word: w};
		file_rdata <= f;
		@(posedge aclk);
		instr.valid <= 1'b0;
		#1;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic s_regs();
		chk(32'({timeout_flag, powerdown_flag, halted, osc_run}), 32'hd);
		axi_rd(REG_STATUS);
		chk(rd_val, 32'h0000_0058);
		axi_rd(REG_CTRL);
		chk(rd_val, 32'h0000_0001);
		axi_rd(4'hc);
		chk(rd_val, 32'h0000_0000);
		chk(32'(rd_resp), 32'(RESP_SLVERR));
		axi_wr(REG_STATUS, 32'h0000_0000);
		chk(32'(wr_resp), 32'(RESP_OKAY));
	endtask

	task automatic s_lit();
		logic [15:0] cases [5] = '{16'h0201, 16'h0202, 16'h0203,
			16'h1001, 16'h0080};
		for (int i = 0; i < 5; i++)
		begin
			axi_wr(REG_WORK, 32'(cases[i][7:0]));
			ex({OP_LIT_SUB, 1'(i), cases[i][15:8]}, 8'h00);
			chk(32'({w_reg, carry, digit_carry_flag, zero}),
				32'(sub_exp(cases[i][15:8], cases[i][7:0])));
		end
	endtask

	task automatic s_reg();
		logic [7:0] fv;
		for (int i = 0; i < 6; i++)
		begin
			fv = (i < 2) ? 8'h03 : ((i < 4) ? 8'h01 : 8'h02);
			axi_wr(REG_WORK, 32'h0000_0002);
			ex({OP_REG_SUB, 1'(i), 7'h15}, fv);
			chk(32'({carry, digit_carry_flag, zero}),
				32'(sub_exp(fv, 8'h02) & 11'h007));
			chk(32'(file_wr.en), 32'(i[0]));
			if (i[0])
				chk(32'({file_wr.addr, file_wr.data, w_reg}),
					32'({7'h15, fv - 8'h02, 8'h02}));
			else
				chk(32'(w_reg), 32'(8'(fv - 8'h02)));
			@(posedge aclk);
			#1;
			chk(32'(file_wr.en), 32'h0000_0000);
		end
	endtask

	task automatic s_halt();
		w_old = w_reg;
		ex(OP_HALT, 8'h00);
		chk(32'({watchdog_clear, timeout_flag, powerdown_flag}),
			32'h6);
		chk(32'({halted, osc_run}), 32'h2);
		@(posedge aclk);
		#1;
		chk(32'(watchdog_clear), 32'h0);
		axi_rd(REG_STATUS);
		chk(rd_val, 32'h0000_0037);
		ex({OP_LIT_SUB, 1'b0, 8'h55}, 8'h00);
		chk(32'({w_reg, halted}), 32'({w_old, 1'b1}));
		@(posedge aclk);
		wake_event <= 1'b1;
		@(posedge aclk);
		wake_event <= 1'b0;
		#1;
		chk(32'({halted, osc_run}), 32'h1);
	endtask

	task automatic s_ctrl();
		clk_en <= 1'b0;
		w_old = w_reg;
		ex({OP_LIT_SUB, 1'b0, 8'h77}, 8'h00);
		chk(32'(w_reg), 32'(w_old));
		clk_en <= 1'b1;
		axi_wr(REG_CTRL, 32'h0000_0000);
		w_old = w_reg;
		ex({OP_LIT_SUB, 1'b0, 8'h77}, 8'h00);
		chk(32'(w_reg), 32'(w_old));
		axi_wr(REG_CTRL, 32'h0000_0001);
		ex({OP_LIT_SUB, 1'b0, 8'h77}, 8'h00);
		chk(32'(w_reg), 32'(8'(8'h77 - w_old)));
		axi_rd(REG_WORK);
		chk(rd_val, 32'(8'(8'h77 - w_old)));
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		clk_en = 1'b1;
		wake_event = 1'b0;
		instr = '0;
		file_rdata = 8'h00;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		#1;
		s_regs();
		s_lit();
		s_reg();
		s_halt();
		s_ctrl();
		finish_test();
	end
endmodule

`default_nettype wire

// file: verilog/sleep_and_subtract_exec.sv
// Decode and execute of the halt and the two subtract instructions
`timescale 1ns/1ps
`default_nettype none

module sleep_and_subtract_exec
	import sse_pkg::*;
#(
	parameter int AXI_ADDR_W = 4
)(
	// Clock, reset, enable
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic                  clk_en,
	// Fetched instruction, file register read port and wake-up event
	input  wire instr_t                instr,
	input  wire logic [7:0]            file_rdata,
	input  wire logic                  wake_event,
	// File register write, core state
	output var  file_wr_t              file_wr,
	output var  logic [7:0]            w_reg,
	output var  logic                  carry,
	output var  logic                  digit_carry_flag,
	output var  logic                  zero,
	output var  logic                  timeout_flag,
	output var  logic                  powerdown_flag,
	output var  logic                  halted,
	output var  logic                  osc_run,
	output var  logic                  watchdog_clear,
	// AXI4-Lite slave
	input  wire logic [AXI_ADDR_W-1:0] awaddr,
	input  wire logic                  awvalid,
	output var  logic                  awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output var  logic                  wready,
	output var  logic [1:0]            bresp,
	output var  logic                  bvalid,
	input  wire logic                  bready,
	input  wire logic [AXI_ADDR_W-1:0] araddr,
	input  wire logic                  arvalid,
	output var  logic                  arready,
	output var  logic [31:0]           rdata,
	output var  logic [1:0]            rresp,
	output var  logic                  rvalid,
	input  wire logic                  rready
);

	// ----------------------------------------------------------------
	// Types and helpers
	// ----------------------------------------------------------------
	typedef struct packed {
		core_state_t           core;
		logic [7:0]            w_reg;
		logic                  carry;
		logic                  digit_carry;
		logic                  zero;
		logic                  timeout;
		logic                  powerdown;
		logic                  osc;
		logic                  wd_clear;
		logic                  exec_en;
		file_wr_t              fwr;
		logic                  aw_got;
		logic                  w_got;
		logic [AXI_ADDR_W-1:0] aw_addr;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  awready;
		logic                  wready;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [1:0]            rresp;
		logic [31:0]           rdata;
	} state_t;

	if (AXI_ADDR_W < 4)
		$error("AXI_ADDR_W must be at least 4");

	// Eight-bit subtract a - b with borrow-style flags
	function automatic alu_t sub_calc(input logic [7:0] a, b);
		alu_t        r;
		logic [8:0]  d;
		logic [4:0]  n;
		d    = {1'b0, a} - {1'b0, b};
		n    = {1'b0, a[3:0]} - {1'b0, b[3:0]};
		r.res = d[7:0];
		r.c   = ~d[8];
		r.digit_carry = ~n[4];
		r.z   = (d[7:0] == 8'h00);
		return r;
	endfunction

	// Register index: 0 status, 1 work, 2 control, 3 unmapped
	function automatic logic [1:0] reg_sel(input logic [AXI_ADDR_W-1:0] a);
		if (a == AXI_ADDR_W'(REG_STATUS))
			return 2'd0;
		if (a == AXI_ADDR_W'(REG_WORK))
			return 2'd1;
		if (a == AXI_ADDR_W'(REG_CTRL))
			return 2'd2;
		return 2'd3;
	endfunction

	state_t st;
	state_t next_st;
	logic   exe;
	logic   is_halt;
	logic   is_lit;
	logic   is_reg;
	alu_t   lit_alu;
	alu_t   reg_alu;
	assign exe     = instr.valid && (st.core == CORE_RUN) && st.exec_en;
	assign is_halt = exe && (instr.word == OP_HALT);
	assign is_lit  = exe && (instr.word[13:9] == OP_LIT_SUB);
	assign is_reg  = exe && (instr.word[13:8] == OP_REG_SUB);
	assign lit_alu = sub_calc(instr.word[7:0], st.w_reg);
	assign reg_alu = sub_calc(file_rdata, st.w_reg);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st          = st;
		next_st.wd_clear = 1'b0;
		next_st.fwr.en   = 1'b0;
		// Bus write: address and data taken in either order
		if (awvalid && st.awready)
		begin
			next_st.aw_got  = 1'b1;
			next_st.aw_addr = awaddr;
		end
		if (wvalid && st.wready)
		begin
			next_st.w_got  = 1'b1;
			next_st.w_data = wdata;
			next_st.w_strb = wstrb;
		end
		if (st.bvalid && bready)
			next_st.bvalid = 1'b0;
		if (next_st.aw_got && next_st.w_got && !next_st.bvalid)
		begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = RESP_OKAY;
			case (reg_sel(next_st.aw_addr))
				2'd1:
					if (next_st.w_strb[0])
						next_st.w_reg = next_st.w_data[7:0];
				2'd2:
					if (next_st.w_strb[0])
						next_st.exec_en = next_st.w_data[CTRL_EXEC_EN];
				2'd0:
					next_st.bresp = RESP_OKAY;
				default:
					next_st.bresp = RESP_SLVERR;
			endcase
		end
		next_st.awready = !next_st.aw_got && !next_st.bvalid;
		next_st.wready  = !next_st.w_got && !next_st.bvalid;
		// Bus read
		if (st.rvalid && rready)
		begin
			next_st.rvalid  = 1'b0;
			next_st.arready = 1'b1;
		end
		if (arvalid && st.arready)
		begin
			next_st.rvalid  = 1'b1;
			next_st.arready = 1'b0;
			next_st.rresp   = RESP_OKAY;
			next_st.rdata   = RDATA_ZERO;
			case (reg_sel(araddr))
				2'd0:
				begin
					next_st.rdata[ST_CARRY] = st.carry;
					next_st.rdata[ST_DIGIT_CARRY] = st.digit_carry;
					next_st.rdata[ST_ZERO]  = st.zero;
					next_st.rdata[ST_POWERDOWN]   = st.powerdown;
					next_st.rdata[ST_TIMEOUT]     = st.timeout;
					next_st.rdata[ST_HALT]  = (st.core == CORE_HALT);
					next_st.rdata[ST_OSC]   = st.osc;
				end
				2'd1:
					next_st.rdata[7:0] = st.w_reg;
				2'd2:
					next_st.rdata[CTRL_EXEC_EN] = st.exec_en;
				default:
					next_st.rresp = RESP_SLVERR;
			endcase
		end
		// Core: an executed instruction wins over a bus write to W
		case (st.core)
			CORE_RUN:
				if (is_halt)
				begin
					next_st.wd_clear  = 1'b1;
					next_st.timeout   = 1'b1;
					next_st.powerdown = 1'b0;
					next_st.core      = CORE_HALT;
					next_st.osc       = 1'b0;
				end
				else if (is_lit)
				begin
					next_st.w_reg       = lit_alu.res;
					next_st.carry       = lit_alu.c;
					next_st.digit_carry = lit_alu.digit_carry;
					next_st.zero        = lit_alu.z;
				end
				else if (is_reg)
				begin
					next_st.carry       = reg_alu.c;
					next_st.digit_carry = reg_alu.digit_carry;
					next_st.zero        = reg_alu.z;
					if (instr.word[DEST_BIT])
					begin
						next_st.fwr.en   = 1'b1;
						next_st.fwr.addr = instr.word[FADDR_W-1:0];
						next_st.fwr.data = reg_alu.res;
					end
					else
						next_st.w_reg = reg_alu.res;
				end
			CORE_HALT:
				if (wake_event)
				begin
					next_st.core = CORE_RUN;
					next_st.osc  = 1'b1;
				end
			default:
			begin
				next_st.core = CORE_RUN;
				next_st.osc  = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st         <= '0;
			st.core    <= CORE_RUN;
			st.w_reg   <= W_RST;
			st.timeout   <= TIMEOUT_RST;
			st.powerdown <= POWERDOWN_RST;
			st.osc     <= 1'b1;
			st.exec_en <= EXEC_RST;
			st.awready <= 1'b1;
			st.wready  <= 1'b1;
			st.arready <= 1'b1;
		end
		else if (clk_en)
			st <= next_st;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign file_wr          = st.fwr;
	assign w_reg            = st.w_reg;
	assign carry            = st.carry;
	assign digit_carry_flag = st.digit_carry;
	assign zero             = st.zero;
	assign timeout_flag     = st.timeout;
	assign powerdown_flag   = st.powerdown;
	assign halted           = (st.core == CORE_HALT);
	assign osc_run          = st.osc;
	assign watchdog_clear   = st.wd_clear;
	assign awready          = st.awready;
	assign wready           = st.wready;
	assign bvalid           = st.bvalid;
	assign bresp            = st.bresp;
	assign arready          = st.arready;
	assign rvalid           = st.rvalid;
	assign rresp            = st.rresp;
	assign rdata            = st.rdata;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_halt_flags: assert property (@(posedge aclk) disable iff (!aresetn)
		is_halt && clk_en |=> watchdog_clear && timeout_flag
			&& !powerdown_flag && halted)
		else $error("halt did not clear watchdog or set flags");
	a_halt_osc: assert property (@(posedge aclk) disable iff (!aresetn)
		halted |-> !osc_run && !file_wr.en)
		else $error("oscillator runs while halted");
	a_halt_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		halted && !wake_event |=> halted && $stable(w_reg)
			|| !$past(clk_en) || $past(bvalid) != bvalid)
		else $error("halt left without wake-up");
	a_lit_result: assert property (@(posedge aclk) disable iff (!aresetn)
		is_lit && clk_en |=>
			w_reg == 8'($past(instr.word[7:0]) - $past(w_reg)))
		else $error("literal subtract result wrong");
	a_dest_file: assert property (@(posedge aclk) disable iff (!aresetn)
		is_reg && clk_en && instr.word[DEST_BIT] |=> file_wr.en
			&& file_wr.data == 8'($past(file_rdata) - $past(w_reg))
			&& file_wr.addr == $past(instr.word[FADDR_W-1:0]))
		else $error("file write-back wrong");
	a_dest_work: assert property (@(posedge aclk) disable iff (!aresetn)
		is_reg && clk_en && !instr.word[DEST_BIT] |=> !file_wr.en
			&& w_reg == 8'($past(file_rdata) - $past(w_reg)))
		else $error("register subtract into W wrong");
	a_carry_lit: assert property (@(posedge aclk) disable iff (!aresetn)
		is_lit && clk_en |=>
			carry == ($past(instr.word[7:0]) >= $past(w_reg)))
		else $error("carry wrong after literal subtract");
	a_carry_reg: assert property (@(posedge aclk) disable iff (!aresetn)
		is_reg && clk_en |=> carry == ($past(file_rdata) >= $past(w_reg)))
		else $error("carry wrong after register subtract");
	a_zero_dc: assert property (@(posedge aclk) disable iff (!aresetn)
		is_reg && clk_en |=> zero == ($past(file_rdata) == $past(w_reg))
			&& digit_carry_flag ==
			($past(file_rdata[3:0]) >= $past(w_reg[3:0])))
		else $error("zero or digit carry wrong");

endmodule

`default_nettype wire

// file: verilog/sse_pkg.sv
// Constants, types and register map of the halt and subtract executor
package sse_pkg;

	// ----------------------------------------------------------------
	// Instruction encodings
	// ----------------------------------------------------------------
	localparam logic [13:0] OP_HALT    = 14'h0063;
	localparam logic [4:0]  OP_LIT_SUB = 5'h1e;
	localparam logic [5:0]  OP_REG_SUB = 6'h02;
	localparam int          DEST_BIT   = 7;
	localparam int          FADDR_W    = 7;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and field positions
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_WORK   = 4'h4;
	localparam logic [3:0] REG_CTRL   = 4'h8;
	localparam int ST_CARRY = 0;
	localparam int ST_DIGIT_CARRY = 1;
	localparam int ST_ZERO  = 2;
	localparam int ST_POWERDOWN   = 3;
	localparam int ST_TIMEOUT     = 4;
	localparam int ST_HALT  = 5;
	localparam int ST_OSC   = 6;
	localparam int CTRL_EXEC_EN = 0;

	// ----------------------------------------------------------------
	// Reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [7:0]  W_RST      = 8'h00;
	localparam logic        TIMEOUT_RST   = 1'b1;
	localparam logic        POWERDOWN_RST = 1'b1;
	localparam logic        EXEC_RST   = 1'b1;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CORE_RUN  = 2'b01,
		CORE_HALT = 2'b10
	} core_state_t;

	typedef struct packed {
		logic        valid;
		logic [13:0] word;
	} instr_t;

	typedef struct packed {
		logic               en;
		logic [FADDR_W-1:0] addr;
		logic [7:0]         data;
	} file_wr_t;

	typedef struct packed {
		logic [7:0] res;
		logic       c;
		logic       digit_carry;
		logic       z;
	} alu_t;

endpackage
